// ==== fpms_regs.svh ====
/*
 fpms_regs.svh: timing counts and level codes for the flyback protection mode sequencer.
 assumes a 200 MHz ref_clk; overload blanking and max on-time counts derived from times in their own units, ovp and burst blanking given in cycles.
*/
`ifndef FPMS_REGS_SVH
`define FPMS_REGS_SVH
`define FPMS_CLK_MHZ            200
`define FPMS_OVLD_BLANK_MS      24
`define FPMS_OVLD_BLANK_CYC     (`FPMS_OVLD_BLANK_MS * 1000 * `FPMS_CLK_MHZ)
`define FPMS_MAX_ON_US          30
`define FPMS_MAX_ON_CYC         (`FPMS_MAX_ON_US * `FPMS_CLK_MHZ)
`define FPMS_OVP_BLANK_CYC      64
`define FPMS_BURST_BLANK_CYC    4096
`define FPMS_UDC_BURST_VAL      3'h7
`define FPMS_UDC_EXIT_VAL       3'h1
`define FPMS_ILIM_FULL          2'h0
`define FPMS_ILIM_BURST         2'h1
`endif

// ==== fpms_pkg.sv ====
/*
 fpms_pkg: state types of the flyback protection mode sequencer.
 assumes fpms_regs.svh is included by the design file.
*/
package fpms_pkg;
    typedef enum logic [2:0] {
        FPMS_ST_RESET,
        FPMS_ST_RUN,
        FPMS_ST_BURST,
        FPMS_ST_AUTO_RESTART,
        FPMS_ST_LATCHED
    } fpms_mode_t;
endpackage : fpms_pkg

// ==== fpms_sequencer.sv ====
/*
 fpms_sequencer: mode and protection sequencer of a quasi-resonant flyback controller.
 assumes comparator flags arrive asynchronously and the gate request comes from
 the pwm logic on ref_clk; srst is the supply undervoltage reset.
*/
`timescale 1ns/1ps
`include "fpms_regs.svh"

module fpms_sequencer #(
    parameter int unsigned OVLD_BLANK_CYC  = `FPMS_OVLD_BLANK_CYC,
    parameter int unsigned MAX_ON_CYC      = `FPMS_MAX_ON_CYC,
    parameter int unsigned OVP_BLANK_CYC   = `FPMS_OVP_BLANK_CYC,
    parameter int unsigned BURST_BLANK_CYC = `FPMS_BURST_BLANK_CYC
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             srst,
    // comparator flags, asynchronous
    input  wire logic             feedback_high,
    input  wire logic             feedback_above_exit,
    input  wire logic             feedback_below_entry,
    input  wire logic             zc_overvoltage,
    input  wire logic             short_winding,
    input  wire logic             over_temp,
    input  wire logic             supply_below_off,
    input  wire logic             supply_above_on,
    input  wire logic             supply_overvoltage,
    // pwm side, same clock
    input  wire logic             gate_request,
    input  wire logic [2:0]       udc_value,
    // outputs
    output logic                  gate_drive,
    output logic                  startup_cell_en,
    output logic                  soft_start,
    output logic [1:0]            ilim_select,
    output logic                  udc_load,
    output logic [2:0]            udc_load_value,
    output fpms_pkg::fpms_mode_t  mode
);
    import fpms_pkg::*;

    localparam int NSYNC = 9;

    typedef struct packed {
        logic [NSYNC-1:0] s1;
        logic [NSYNC-1:0] s2;
        logic [NSYNC-1:0] s3;
        logic [NSYNC-1:0] flt;
        fpms_mode_t       st;
        logic [31:0]      ovld_cnt;
        logic [31:0]      on_cnt;
        logic [31:0]      ovp_cnt;
        logic [31:0]      bst_cnt;
        logic             recharged;
        logic             gate;
        logic             startup;
        logic             ss;
        logic [1:0]       ilim;
        logic             udc_ld;
        logic [2:0]       udc_val;
    } fpms_state_t;

    fpms_state_t q;
    fpms_state_t d;
    logic [NSYNC-1:0] raw;
    logic [NSYNC-1:0] flt;
    logic [NSYNC-1:0] flt_d;

    assign raw = {supply_overvoltage, supply_above_on, supply_below_off, over_temp,
                  short_winding, zc_overvoltage, feedback_below_entry,
                  feedback_above_exit, feedback_high};

    // a change counts only when second and third stage agree
    // one filter per flag keeps comparator chatter out of the mode logic
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_flt
            assign flt_d[gi] = (q.s2[gi] == q.s3[gi]) ? q.s3[gi] : q.flt[gi];
        end
    endgenerate
    assign flt = q.flt;

    logic fb_hi, fb_exit, fb_entry, zc_ov, sw_sh, otp, vcc_lo, vcc_on, vcc_ov;
    assign {vcc_ov, vcc_on, vcc_lo, otp, sw_sh, zc_ov, fb_entry, fb_exit, fb_hi} = flt;

    always_comb begin
        d         = q;
        d.s1      = raw;
        d.s2      = q.s1;
        d.s3      = q.s2;
        d.flt     = flt_d;
        d.udc_ld  = 1'b0;
        d.ss      = 1'b0;
        case (q.st)
            FPMS_ST_RESET: begin
                d.gate = 1'b0;
                d.ilim = `FPMS_ILIM_FULL;
                if (vcc_lo) begin
                    d.startup = 1'b1;
                end
                if (vcc_on && d.startup) begin
                    d.startup = 1'b0;
                    d.ss      = 1'b1;
                    d.st      = FPMS_ST_RUN;
                end
            end
            FPMS_ST_RUN, FPMS_ST_BURST: begin
                d.gate = gate_request;
                // max on-time cut-off
                if (q.gate && q.on_cnt >= MAX_ON_CYC - 1) begin
                    d.gate = 1'b0;
                end
                // 32-bit counters: the full overload blanking fits at 200 MHz
                d.on_cnt  = q.gate ? q.on_cnt + 32'h1 : 32'h0;
                d.ovld_cnt = fb_hi ? q.ovld_cnt + 32'h1 : 32'h0;
                d.ovp_cnt  = (!q.gate && zc_ov) ? q.ovp_cnt + 32'h1 : 32'h0;
                if (q.st == FPMS_ST_RUN) begin
                    d.ilim    = `FPMS_ILIM_FULL;
                    d.bst_cnt = (fb_entry && udc_value == `FPMS_UDC_BURST_VAL)
                                ? q.bst_cnt + 32'h1 : 32'h0;
                    if (q.bst_cnt >= BURST_BLANK_CYC - 1) begin
                        d.st      = FPMS_ST_BURST;
                        d.ilim    = `FPMS_ILIM_BURST;
                        d.bst_cnt = 32'h0;
                    end
                end else if (fb_exit) begin
                    d.st      = FPMS_ST_RUN;
                    d.ilim    = `FPMS_ILIM_FULL;
                    d.udc_ld  = 1'b1;
                    d.udc_val = `FPMS_UDC_EXIT_VAL;
                end
                // auto-restart faults; latch-off faults take priority
                if (q.ovld_cnt >= OVLD_BLANK_CYC - 1 || otp || vcc_ov) begin
                    d.st = FPMS_ST_AUTO_RESTART;
                end
                if (q.ovp_cnt >= OVP_BLANK_CYC - 1) begin
                    d.st = FPMS_ST_LATCHED;
                end
                if (q.gate && sw_sh) begin
                    d.st = FPMS_ST_LATCHED;
                end
                if (d.st == FPMS_ST_AUTO_RESTART || d.st == FPMS_ST_LATCHED) begin
                    d.gate      = 1'b0;
                    d.ilim      = `FPMS_ILIM_FULL;
                    d.recharged = 1'b0;
                    d.ovld_cnt  = 32'h0;
                    d.ovp_cnt   = 32'h0;
                    d.bst_cnt   = 32'h0;
                end
            end
            FPMS_ST_AUTO_RESTART: begin
                // discharge to turn-off level, recharge, then restart
                d.gate = 1'b0;
                if (vcc_lo) begin
                    d.startup   = 1'b1;
                    d.recharged = 1'b1;
                end
                if (q.recharged && vcc_on) begin
                    d.startup = 1'b0;
                    d.ss      = 1'b1;
                    d.st      = FPMS_ST_RUN;
                end
            end
            FPMS_ST_LATCHED: begin
                // only removing power (srst) leaves this state
                // a supply dip alone only cycles the startup cell
                d.gate = 1'b0;
                if (vcc_lo) begin
                    d.startup = 1'b1;
                end else if (vcc_on) begin
                    d.startup = 1'b0;
                end
            end
            default: begin
                d.st   = FPMS_ST_RESET;
                d.gate = 1'b0;
            end
        endcase
        // supply undervoltage while active resets the controller
        // limitation: it also ends a latch fault raised in the same cycle
        if (vcc_lo && (q.st == FPMS_ST_RUN || q.st == FPMS_ST_BURST)) begin
            d.st      = FPMS_ST_RESET;
            d.gate    = 1'b0;
            d.startup = 1'b1;
            d.ilim    = `FPMS_ILIM_FULL;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            q         <= '0;
            q.st      <= FPMS_ST_RESET;
            q.startup <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign gate_drive      = q.gate;
    assign startup_cell_en = q.startup;
    assign soft_start      = q.ss;
    assign ilim_select     = q.ilim;
    assign udc_load        = q.udc_ld;
    assign udc_load_value  = q.udc_val;
    assign mode            = q.st;
endmodule : fpms_sequencer

// ==== fpms_power_stage.sv ====
/* fpms_power_stage: switch, windings and sense network behind the sequencer.
   assumes the bench picks the fault to show through the enables. */
`timescale 1ns/1ps
module fpms_power_stage (
    // gate and fault picks
    input  wire logic gate_drive,
    input  wire logic short_en,
    input  wire logic ovp_en,
    // comparator flags
    output logic      short_winding,
    output logic      zc_overvoltage
);
    // each fault only in the phase its sensing covers
    assign short_winding  = gate_drive & short_en;
    assign zc_overvoltage = ~gate_drive & ovp_en;
endmodule : fpms_power_stage

// ==== fpms_sequencer_properties.sv ====
/* fpms_sequencer_properties: port checks on the sequencer.
   assumes it is bound into fpms_sequencer. */
`timescale 1ns/1ps
module fpms_sequencer_properties
    import fpms_pkg::*;
#(parameter int unsigned MAX_ON_CYC = 20) (
    // watched ports
    input wire logic       ref_clk,
    input wire logic       srst,
    input wire logic       gate_drive,
    input wire logic       startup_cell_en,
    input wire logic       udc_load,
    input wire logic [1:0] ilim_select,
    input wire logic [2:0] udc_load_value,
    input wire fpms_mode_t mode
);
    int unsigned on_q;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    // run length of the gate high
    always_ff @(posedge ref_clk) on_q <= (srst || !gate_drive) ? 0 : on_q + 1;
    property p_rst; disable iff (1'b0) srst |=> mode == FPMS_ST_RESET && startup_cell_en;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state");
    property p_on; on_q <= MAX_ON_CYC; endproperty
    a_on: assert property (p_on) else $error("on too long");
    property p_bil; mode == FPMS_ST_BURST |-> ilim_select == 2'h1; endproperty
    a_bil: assert property (p_bil) else $error("burst limit");
    property p_ex; mode == FPMS_ST_RUN && $past(mode) == FPMS_ST_BURST |-> udc_load &&
        udc_load_value == 3'h1 && ilim_select == 2'h0; endproperty
    a_ex: assert property (p_ex) else $error("burst exit");
    property p_ul; udc_load |=> !udc_load; endproperty
    a_ul: assert property (p_ul) else $error("load pulse");
    property p_lh; mode == FPMS_ST_LATCHED |=> mode == FPMS_ST_LATCHED; endproperty
    a_lh: assert property (p_lh) else $error("latch left");
    property p_lg; mode == FPMS_ST_LATCHED |=> !gate_drive; endproperty
    a_lg: assert property (p_lg) else $error("gate in latch");
    property p_ag; mode == FPMS_ST_AUTO_RESTART |=> !gate_drive; endproperty
    a_ag: assert property (p_ag) else $error("gate in restart");
    c_bu: cover property (mode == FPMS_ST_BURST);
    c_la: cover property (mode == FPMS_ST_LATCHED);
    c_ar: cover property (mode == FPMS_ST_AUTO_RESTART);
    c_ex: cover property (udc_load);
endmodule : fpms_sequencer_properties
bind fpms_sequencer fpms_sequencer_properties #(.MAX_ON_CYC(MAX_ON_CYC)) u_props (.ref_clk,
    .srst, .gate_drive, .startup_cell_en, .udc_load, .ilim_select, .udc_load_value, .mode);

// ==== fpms_sequencer_bench.sv ====
/* fpms_sequencer_bench: directed mode and fault scenarios.
   assumes fpms_power_stage as far side and the bound checker. */
`timescale 1ns/1ps
module fpms_sequencer_bench;
    import fpms_pkg::*;
    localparam int MAX_ON = 20;
    logic ref_clk = 1'h0, srst = 1'h1, gate_request = 1'h0, short_en = 1'h0, ovp_en = 1'h0;
    logic feedback_high = 1'h0, feedback_above_exit = 1'h0, feedback_below_entry = 1'h0;
    logic over_temp = 1'h0, supply_below_off = 1'h0, supply_above_on = 1'h0;
    logic supply_overvoltage = 1'h0, gate_drive, startup_cell_en, soft_start, udc_load;
    logic zc_overvoltage, short_winding;
    logic [2:0] udc_value = 3'h0, udc_load_value;
    logic [1:0] ilim_select;
    fpms_mode_t mode;
    int fails = 0, samples_checked = 0, ss_n = 0;
    always #2.5 ref_clk = ~ref_clk;
    always @(negedge ref_clk) if (soft_start === 1'h1) ss_n++;
    fpms_sequencer #(.OVLD_BLANK_CYC(50), .MAX_ON_CYC(MAX_ON), .OVP_BLANK_CYC(8),
        .BURST_BLANK_CYC(16)) u_dut (.ref_clk, .srst, .feedback_high, .feedback_above_exit,
        .feedback_below_entry, .zc_overvoltage, .short_winding, .over_temp, .supply_below_off,
        .supply_above_on, .supply_overvoltage, .gate_request, .udc_value, .gate_drive,
        .startup_cell_en, .soft_start, .ilim_select, .udc_load, .udc_load_value, .mode);
    fpms_power_stage u_stage (.gate_drive, .short_en, .ovp_en, .short_winding, .zc_overvoltage);
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : step
    task automatic chk(input logic [7:0] seen, input logic [7:0] want);
        samples_checked++;
        if (seen !== want) begin
            fails++;
            $display("CHECK FAILED %0t saw %h want %h", $time, seen, want);
        end
    endtask : chk
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : finish_test
    // bounded wait, a miss ends the run
    task automatic wait_mode(input fpms_mode_t m, input int bound);
        for (int i = 0; i < bound && mode !== m; i++) step(1);
        chk(mode, m);
        if (mode !== m) finish_test();
    endtask : wait_mode
    // supply dips below turn-off then climbs past turn-on
    task automatic recycle();
        supply_below_off = 1'h1;
        step(8);
        chk(startup_cell_en, 1'h1);
        supply_below_off = 1'h0;
        supply_above_on = 1'h1;
        wait_mode(FPMS_ST_RUN, 20);
        supply_above_on = 1'h0;
    endtask : recycle
    // max on-time cut-off, then a supply dip while running
    task automatic t_maxon_uv();
        chk(gate_drive, 1'h0);
        gate_request = 1'h1;
        step(1);
        chk(gate_drive, 1'h1);
        step(MAX_ON - 1);
        chk(gate_drive, 1'h1);
        step(1);
        chk(gate_drive, 1'h0);
        step(1);
        chk(gate_drive, 1'h1);
        supply_below_off = 1'h1;
        wait_mode(FPMS_ST_RESET, 10);
        chk(gate_drive, 1'h0);
        chk(startup_cell_en, 1'h1);
        recycle();
    endtask : t_maxon_uv
    task automatic t_burst();
        feedback_below_entry = 1'h1;
        udc_value = 3'h7;
        wait_mode(FPMS_ST_BURST, 40);
        chk(ilim_select, 2'h1);
        feedback_below_entry = 1'h0;
        feedback_above_exit = 1'h1;
        for (int i = 0; i < 20 && udc_load !== 1'h1; i++) step(1);
        chk(udc_load, 1'h1);
        if (udc_load !== 1'h1) finish_test();
        chk(udc_load_value, 3'h1);
        chk(ilim_select, 2'h0);
        chk(mode, FPMS_ST_RUN);
        feedback_above_exit = 1'h0;
        udc_value = 3'h0;
    endtask : t_burst
    task automatic t_auto();
        feedback_high = 1'h1;
        step(45);
        chk(mode, FPMS_ST_RUN);
        wait_mode(FPMS_ST_AUTO_RESTART, 30);
        feedback_high = 1'h0;
        recycle();
        for (int k = 0; k < 2; k++) begin
            {supply_overvoltage, over_temp} = 2'h1 << k;
            wait_mode(FPMS_ST_AUTO_RESTART, 20);
            {supply_overvoltage, over_temp} = 2'h0;
            recycle();
        end
    endtask : t_auto
    task automatic t_latch();
        short_en = 1'h1;
        wait_mode(FPMS_ST_LATCHED, 30);
        short_en = 1'h0;
        supply_below_off = 1'h1;
        step(8);
        chk(startup_cell_en, 1'h1);
        supply_below_off = 1'h0;
        supply_above_on = 1'h1;
        step(8);
        chk(startup_cell_en, 1'h0);
        chk(mode, FPMS_ST_LATCHED);
        supply_above_on = 1'h0;
        srst = 1'h1;
        step(2);
        srst = 1'h0;
        recycle();
        // off-time must outlast the overvoltage blanking
        gate_request = 1'h0;
        ovp_en = 1'h1;
        wait_mode(FPMS_ST_LATCHED, 30);
    endtask : t_latch
    initial begin
        step(16);
        srst = 1'h0;
        chk(mode, FPMS_ST_RESET);
        recycle();
        t_maxon_uv();
        t_burst();
        t_auto();
        t_latch();
        chk(ss_n, 6);
        finish_test();
    end
endmodule : fpms_sequencer_bench
